// ==== src/tpw_pkg.sv ====
// constants, register map and carrier types for the three-phase pwm controller
package tpw_pkg;

  // ----------------------------------------------------------------
  // register byte offsets on apb
  // ----------------------------------------------------------------
  localparam logic [7:0] TPW_OFS_HALF_PERIOD = 8'h00;
  localparam logic [7:0] TPW_OFS_DEAD_TIME = 8'h04;
  localparam logic [7:0] TPW_OFS_MIN_PULSE = 8'h08;
  localparam logic [7:0] TPW_OFS_SYNC_WIDTH = 8'h0C;
  localparam logic [7:0] TPW_OFS_DUTY_A = 8'h10;
  localparam logic [7:0] TPW_OFS_DUTY_B = 8'h14;
  localparam logic [7:0] TPW_OFS_DUTY_C = 8'h18;
  localparam logic [7:0] TPW_OFS_SEGMENT = 8'h1C;
  localparam logic [7:0] TPW_OFS_GATE = 8'h20;
  localparam logic [7:0] TPW_OFS_MODE = 8'h24;
  localparam logic [7:0] TPW_OFS_SOFT_SHUT = 8'h28;
  localparam logic [7:0] TPW_OFS_STATUS = 8'h2C;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int TPW_CNT_W = 16;
  localparam int TPW_DT_W = 10;
  localparam int TPW_SW_W = 8;
  localparam int TPW_SEG_W = 9;
  localparam int TPW_GATE_W = 10;
  localparam int TPW_ARITH_W = 18;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int TPW_SEG_EN_LSB = 0;   // six output enables, a_hi a_lo b_hi b_lo c_hi c_lo
  localparam int TPW_SEG_XO_LSB = 6;   // three crossover bits, phase a b c
  localparam int TPW_GATE_FREQ_LSB = 0;
  localparam int TPW_GATE_FREQ_W = 8;
  localparam int TPW_GATE_HI_EN = 8;
  localparam int TPW_GATE_LO_EN = 9;
  localparam int TPW_MODE_DOUBLE = 6;
  localparam int TPW_STAT_TRIP = 0;
  localparam int TPW_STAT_SHUT = 1;
  localparam int TPW_STAT_HALF = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [TPW_CNT_W-1:0] TPW_RST_HALF_PERIOD = 16'h03E8;
  localparam logic [TPW_DT_W-1:0] TPW_RST_DEAD_TIME = 10'h000;
  localparam logic [TPW_CNT_W-1:0] TPW_RST_MIN_PULSE = 16'h0000;
  localparam logic [TPW_SW_W-1:0] TPW_RST_SYNC_WIDTH = 8'h27;
  localparam logic [TPW_CNT_W-1:0] TPW_RST_DUTY = 16'h0000;
  localparam logic [TPW_SEG_W-1:0] TPW_RST_SEGMENT = 9'h03F;
  localparam logic [TPW_GATE_W-1:0] TPW_RST_GATE = 10'h000;
  localparam logic [7:0] TPW_RST_MODE = 8'h00;

  // ----------------------------------------------------------------
  // timing unit states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TPW_HALT = 3'h1,
    TPW_UP = 3'h2,
    TPW_DOWN = 3'h4
  } tpw_state_e;

  // configuration taken into the timing and output units at each sync
  typedef struct packed {
    logic [TPW_CNT_W-1:0] half_period_count;
    logic [TPW_DT_W-1:0] dead_time_count;
    logic [TPW_CNT_W-1:0] min_pulse_count;
    logic [TPW_SW_W-1:0] sync_width_count;
    logic [TPW_CNT_W-1:0] duty_phase_a;
    logic [TPW_CNT_W-1:0] duty_phase_b;
    logic [TPW_CNT_W-1:0] duty_phase_c;
    logic [TPW_SEG_W-1:0] output_segment_ctrl;
  } tpw_cfg_s;

  // current-sense comparator results, one bit per channel
  typedef struct packed {
    logic [2:0] over;
    logic [2:0] under;
    logic [2:0] floating;
  } tpw_sense_s;

endpackage

// ==== src/tpw_pwm_ctrl.sv ====
// three-phase centre-based pwm controller with apb registers and shutdown
//
// Contract
// - six gate outputs, three phases, each with high and low side
// - period, dead time and minimum pulse come from their own registers
// - one duty register per phase sets that phase pair
// - centre-aligned complementary pair per phase, separated by dead time
// - each of six outputs has its own enable bit in segment register
// - per-phase crossover bit swaps high and low waveforms
// - chopping signal mixed in, frequency from 8-bit gate field
// - separate chop enables for high-side group and low-side group
// - single update mode takes new values once per period
// - double update mode also takes new values at period midpoint
// - one mode register bit selects single or double update
// - sync pulse at period start, plus midpoint in double mode
// - sync pulse width comes from sync-width register
// - trip pin low forces all outputs off without a clock edge
// - current sense over, under or floating shuts pwm down
// - hardware shutdown paths are combinational, work without clock
// - software shutdown write acts like a hardware trip
// - shutdown sources combine and hold the timing unit in reset
// - status shows trip pin level and which half of period
// - all counts are in core clock periods
// - separate interrupts for sync pulse and for any shutdown
// - mode bit 6 clear single, set double, cleared by reset
// - status bit 3 zero in first half, one in second half
// - each sync start latches timing, duty and segment values; gate and mode registers act at once
// - sync lasts width plus one cycles, width resets to 0x27
`timescale 1ns/1ps
module tpw_pwm_ctrl (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic trip_pin_n_i,
  input wire tpw_pkg::tpw_sense_s current_sense_input_i,
  output logic phase_a_high_out_o,
  output logic phase_a_low_out_o,
  output logic phase_b_high_out_o,
  output logic phase_b_low_out_o,
  output logic phase_c_high_out_o,
  output logic phase_c_low_out_o,
  output logic period_sync_pulse_o,
  output logic sync_irq_o,
  output logic shutdown_irq_o
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------

  // one phase: {high, low} for position p counted from the period edge
  function automatic logic [1:0] phase_wave(
    input logic [tpw_pkg::TPW_CNT_W-1:0] p,
    input logic [tpw_pkg::TPW_CNT_W-1:0] tm,
    input logic [tpw_pkg::TPW_DT_W-1:0] dt,
    input logic [tpw_pkg::TPW_CNT_W-1:0] pd,
    input logic [tpw_pkg::TPW_CNT_W-1:0] duty
  );
    logic [tpw_pkg::TPW_ARITH_W-1:0] pp;
    logic [tpw_pkg::TPW_ARITH_W-1:0] dd;
    logic [tpw_pkg::TPW_ARITH_W-1:0] edge_pos;
    logic [tpw_pkg::TPW_ARITH_W-1:0] hi_w;
    logic [tpw_pkg::TPW_ARITH_W-1:0] lo_w;
    logic hi;
    logic lo;
    pp = tpw_pkg::TPW_ARITH_W'(p);
    dd = tpw_pkg::TPW_ARITH_W'(dt);
    // switching edge sits (tm - duty) from the period edge
    edge_pos = (duty >= tm) ? '0 : tpw_pkg::TPW_ARITH_W'(tm - duty);
    hi_w = (duty > tpw_pkg::TPW_CNT_W'(dt)) ? tpw_pkg::TPW_ARITH_W'(duty) - dd : '0;
    lo_w = (edge_pos > dd) ? edge_pos - dd : '0;
    // each edge pulled in by dead time, so turn-off to turn-on is 2*dt
    hi = (pp >= edge_pos + dd) && (hi_w >= tpw_pkg::TPW_ARITH_W'(pd));
    lo = (pp + dd < edge_pos) && (lo_w >= tpw_pkg::TPW_ARITH_W'(pd));
    return {hi, lo};
  endfunction

  // register window hit for an apb byte offset
  function automatic logic hit(
    input logic [7:0] addr,
    input logic [7:0] ofs
  );
    return addr == ofs;
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  tpw_pkg::tpw_cfg_s prog_reg;    // software-written shadow values
  tpw_pkg::tpw_cfg_s act_reg;     // values in use by the timing unit
  logic [tpw_pkg::TPW_GATE_W-1:0] gate_reg;
  logic [7:0] mode_reg;
  logic shut_latch_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic addr_ok;
  logic wr_en;
  logic rd_setup;
  tpw_pkg::tpw_state_e state_reg;
  logic [tpw_pkg::TPW_CNT_W-1:0] cnt_reg;
  logic half_reg;
  logic start_ev;
  logic mid_ev;
  logic sync_ev;
  logic [tpw_pkg::TPW_SW_W-1:0] sync_cnt_reg;
  logic sync_reg;
  logic [5:0] raw_reg;            // a_hi a_lo b_hi b_lo c_hi c_lo from timing unit
  logic [5:0] out_reg;            // after crossover, enables and chopping
  logic [5:0] routed;
  logic [tpw_pkg::TPW_GATE_FREQ_W-1:0] chop_cnt_reg;
  logic chop_reg;
  logic hw_fault;
  logic shut_any;
  logic soft_wr;
  logic shut_clr;
  logic double_mode;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------

  // decode of mapped offsets
  always_comb begin
    unique case (paddr_i)
      tpw_pkg::TPW_OFS_HALF_PERIOD, tpw_pkg::TPW_OFS_DEAD_TIME,
      tpw_pkg::TPW_OFS_MIN_PULSE, tpw_pkg::TPW_OFS_SYNC_WIDTH,
      tpw_pkg::TPW_OFS_DUTY_A, tpw_pkg::TPW_OFS_DUTY_B,
      tpw_pkg::TPW_OFS_DUTY_C, tpw_pkg::TPW_OFS_SEGMENT,
      tpw_pkg::TPW_OFS_GATE, tpw_pkg::TPW_OFS_MODE,
      tpw_pkg::TPW_OFS_SOFT_SHUT, tpw_pkg::TPW_OFS_STATUS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // zero-wait slave; the clock enable stretches the access phase
  assign pready_o = ce_i;
  assign pslverr_o = psel_i & penable_i & ~addr_ok;
  assign wr_en = ce_i & psel_i & penable_i & pwrite_i & addr_ok;
  assign rd_setup = psel_i & ~penable_i & ~pwrite_i;
  assign prdata_o = rdata_reg;

  // read mux, registered in the setup phase so data comes from a flop
  always_comb begin
    rdata_next = '0;
    unique case (paddr_i)
      tpw_pkg::TPW_OFS_HALF_PERIOD: rdata_next = 32'(prog_reg.half_period_count);
      tpw_pkg::TPW_OFS_DEAD_TIME: rdata_next = 32'(prog_reg.dead_time_count);
      tpw_pkg::TPW_OFS_MIN_PULSE: rdata_next = 32'(prog_reg.min_pulse_count);
      tpw_pkg::TPW_OFS_SYNC_WIDTH: rdata_next = 32'(prog_reg.sync_width_count);
      tpw_pkg::TPW_OFS_DUTY_A: rdata_next = 32'(prog_reg.duty_phase_a);
      tpw_pkg::TPW_OFS_DUTY_B: rdata_next = 32'(prog_reg.duty_phase_b);
      tpw_pkg::TPW_OFS_DUTY_C: rdata_next = 32'(prog_reg.duty_phase_c);
      tpw_pkg::TPW_OFS_SEGMENT: rdata_next = 32'(prog_reg.output_segment_ctrl);
      tpw_pkg::TPW_OFS_GATE: rdata_next = 32'(gate_reg);
      tpw_pkg::TPW_OFS_MODE: rdata_next = 32'(mode_reg);
      tpw_pkg::TPW_OFS_STATUS: begin
        rdata_next[tpw_pkg::TPW_STAT_TRIP] = trip_pin_n_i;
        rdata_next[tpw_pkg::TPW_STAT_SHUT] = shut_latch_reg;
        rdata_next[tpw_pkg::TPW_STAT_HALF] = half_reg;
      end
      default: rdata_next = '0;
    endcase
  end

  // read data flop
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_reg <= '0;
    end else if (ce_i && rd_setup) begin
      rdata_reg <= rdata_next;
    end
  end

  // programming registers, shadowed until the next sync except gate and mode, which act at once
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      prog_reg.half_period_count <= tpw_pkg::TPW_RST_HALF_PERIOD;
      prog_reg.dead_time_count <= tpw_pkg::TPW_RST_DEAD_TIME;
      prog_reg.min_pulse_count <= tpw_pkg::TPW_RST_MIN_PULSE;
      prog_reg.sync_width_count <= tpw_pkg::TPW_RST_SYNC_WIDTH;
      prog_reg.duty_phase_a <= tpw_pkg::TPW_RST_DUTY;
      prog_reg.duty_phase_b <= tpw_pkg::TPW_RST_DUTY;
      prog_reg.duty_phase_c <= tpw_pkg::TPW_RST_DUTY;
      prog_reg.output_segment_ctrl <= tpw_pkg::TPW_RST_SEGMENT;
      gate_reg <= tpw_pkg::TPW_RST_GATE;
      mode_reg <= tpw_pkg::TPW_RST_MODE;
    end else if (wr_en) begin
      if (hit(paddr_i, tpw_pkg::TPW_OFS_HALF_PERIOD)) begin
        prog_reg.half_period_count <= pwdata_i[tpw_pkg::TPW_CNT_W-1:0];
      end
      if (hit(paddr_i, tpw_pkg::TPW_OFS_DEAD_TIME)) begin
        prog_reg.dead_time_count <= pwdata_i[tpw_pkg::TPW_DT_W-1:0];
      end
      if (hit(paddr_i, tpw_pkg::TPW_OFS_MIN_PULSE)) begin
        prog_reg.min_pulse_count <= pwdata_i[tpw_pkg::TPW_CNT_W-1:0];
      end
      if (hit(paddr_i, tpw_pkg::TPW_OFS_SYNC_WIDTH)) begin
        prog_reg.sync_width_count <= pwdata_i[tpw_pkg::TPW_SW_W-1:0];
      end
      if (hit(paddr_i, tpw_pkg::TPW_OFS_DUTY_A)) begin
        prog_reg.duty_phase_a <= pwdata_i[tpw_pkg::TPW_CNT_W-1:0];
      end
      if (hit(paddr_i, tpw_pkg::TPW_OFS_DUTY_B)) begin
        prog_reg.duty_phase_b <= pwdata_i[tpw_pkg::TPW_CNT_W-1:0];
      end
      if (hit(paddr_i, tpw_pkg::TPW_OFS_DUTY_C)) begin
        prog_reg.duty_phase_c <= pwdata_i[tpw_pkg::TPW_CNT_W-1:0];
      end
      if (hit(paddr_i, tpw_pkg::TPW_OFS_SEGMENT)) begin
        prog_reg.output_segment_ctrl <= pwdata_i[tpw_pkg::TPW_SEG_W-1:0];
      end
      if (hit(paddr_i, tpw_pkg::TPW_OFS_GATE)) begin
        gate_reg <= pwdata_i[tpw_pkg::TPW_GATE_W-1:0];
      end
      if (hit(paddr_i, tpw_pkg::TPW_OFS_MODE)) begin
        mode_reg <= pwdata_i[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // shutdown controller
  // ----------------------------------------------------------------

  // unclocked fault sum, so outputs die even with the clock stopped
  assign hw_fault = ~trip_pin_n_i
    | (|current_sense_input_i.over)
    | (|current_sense_input_i.under)
    | (|current_sense_input_i.floating);
  assign soft_wr = wr_en & hit(paddr_i, tpw_pkg::TPW_OFS_SOFT_SHUT);
  assign shut_clr = wr_en & hit(paddr_i, tpw_pkg::TPW_OFS_STATUS)
    & pwdata_i[tpw_pkg::TPW_STAT_SHUT];
  assign shut_any = hw_fault | shut_latch_reg;

  // sticky shutdown flag; a new fault wins over a software clear
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      shut_latch_reg <= 1'b0;
    end else if (ce_i) begin
      if (hw_fault || soft_wr) begin
        shut_latch_reg <= 1'b1;
      end else if (shut_clr) begin
        shut_latch_reg <= 1'b0;
      end
    end
  end

  // one interrupt pulse as the flag first sets
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      shutdown_irq_o <= 1'b0;
    end else if (ce_i) begin
      shutdown_irq_o <= (hw_fault | soft_wr) & ~shut_latch_reg;
    end
  end

  // ----------------------------------------------------------------
  // timing unit
  // ----------------------------------------------------------------
  assign double_mode = mode_reg[tpw_pkg::TPW_MODE_DOUBLE];
  assign start_ev = ~shut_any & ((state_reg == tpw_pkg::TPW_HALT)
    | ((state_reg == tpw_pkg::TPW_DOWN) & (cnt_reg == '0)));
  assign mid_ev = ~shut_any & (state_reg == tpw_pkg::TPW_UP)
    & (cnt_reg + 1'b1 >= act_reg.half_period_count);
  assign sync_ev = start_ev | (mid_ev & double_mode);

  // up/down counter, each half lasts half_period_count cycles
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_reg <= tpw_pkg::TPW_HALT;
      cnt_reg <= '0;
      half_reg <= 1'b0;
    end else if (ce_i) begin
      if (shut_any) begin
        state_reg <= tpw_pkg::TPW_HALT;
        cnt_reg <= '0;
        half_reg <= 1'b0;
      end else begin
        unique case (state_reg)
          tpw_pkg::TPW_HALT: begin
            state_reg <= tpw_pkg::TPW_UP;
            cnt_reg <= '0;
            half_reg <= 1'b0;
          end
          tpw_pkg::TPW_UP: begin
            if (mid_ev) begin
              state_reg <= tpw_pkg::TPW_DOWN;
              half_reg <= 1'b1;
            end else begin
              cnt_reg <= cnt_reg + 1'b1;
            end
          end
          tpw_pkg::TPW_DOWN: begin
            if (cnt_reg == '0) begin
              state_reg <= tpw_pkg::TPW_UP;
              half_reg <= 1'b0;
            end else begin
              cnt_reg <= cnt_reg - 1'b1;
            end
          end
        endcase
      end
    end
  end

  // take the shadow values at every sync rising edge
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      act_reg.half_period_count <= tpw_pkg::TPW_RST_HALF_PERIOD;
      act_reg.dead_time_count <= tpw_pkg::TPW_RST_DEAD_TIME;
      act_reg.min_pulse_count <= tpw_pkg::TPW_RST_MIN_PULSE;
      act_reg.sync_width_count <= tpw_pkg::TPW_RST_SYNC_WIDTH;
      act_reg.duty_phase_a <= tpw_pkg::TPW_RST_DUTY;
      act_reg.duty_phase_b <= tpw_pkg::TPW_RST_DUTY;
      act_reg.duty_phase_c <= tpw_pkg::TPW_RST_DUTY;
      act_reg.output_segment_ctrl <= tpw_pkg::TPW_RST_SEGMENT;
    end else if (ce_i && sync_ev) begin
      act_reg <= prog_reg;
    end
  end

  // sync pulse of width+1 cycles, restarted by each event
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sync_reg <= 1'b0;
      sync_cnt_reg <= '0;
    end else if (ce_i) begin
      if (sync_ev) begin
        sync_reg <= 1'b1;
        sync_cnt_reg <= prog_reg.sync_width_count;
      end else if (shut_any || sync_cnt_reg == '0) begin
        sync_reg <= 1'b0;
      end else begin
        sync_cnt_reg <= sync_cnt_reg - 1'b1;
      end
    end
  end
  assign period_sync_pulse_o = sync_reg;

  // sync interrupt, one pulse per sync rising edge
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sync_irq_o <= 1'b0;
    end else if (ce_i) begin
      sync_irq_o <= sync_ev;
    end
  end

  // raw complementary pairs from the active values
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      raw_reg <= '0;
    end else if (ce_i) begin
      if (state_reg == tpw_pkg::TPW_HALT) begin
        raw_reg <= '0;
      end else begin
        raw_reg[5:4] <= phase_wave(cnt_reg, act_reg.half_period_count,
          act_reg.dead_time_count, act_reg.min_pulse_count, act_reg.duty_phase_a);
        raw_reg[3:2] <= phase_wave(cnt_reg, act_reg.half_period_count,
          act_reg.dead_time_count, act_reg.min_pulse_count, act_reg.duty_phase_b);
        raw_reg[1:0] <= phase_wave(cnt_reg, act_reg.half_period_count,
          act_reg.dead_time_count, act_reg.min_pulse_count, act_reg.duty_phase_c);
      end
    end
  end

  // ----------------------------------------------------------------
  // output control and gate-drive chopping
  // ----------------------------------------------------------------

  // crossover swaps each pair when its bit is set
  always_comb begin
    routed = raw_reg;
    for (int ph = 0; ph < 3; ph++) begin
      if (act_reg.output_segment_ctrl[tpw_pkg::TPW_SEG_XO_LSB + ph]) begin
        routed[2*ph+1] = raw_reg[2*ph];
        routed[2*ph] = raw_reg[2*ph+1];
      end
    end
  end

  // chop square wave, toggles every field+1 cycles
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      chop_cnt_reg <= '0;
      chop_reg <= 1'b0;
    end else if (ce_i) begin
      if (chop_cnt_reg >= gate_reg[tpw_pkg::TPW_GATE_FREQ_LSB +: tpw_pkg::TPW_GATE_FREQ_W]) begin
        chop_cnt_reg <= '0;
        chop_reg <= ~chop_reg;
      end else begin
        chop_cnt_reg <= chop_cnt_reg + 1'b1;
      end
    end
  end

  // enables then chopping per side group
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      out_reg <= '0;
    end else if (ce_i) begin
      for (int i = 0; i < 6; i++) begin
        out_reg[i] <= routed[i]
          & act_reg.output_segment_ctrl[tpw_pkg::TPW_SEG_EN_LSB + i]
          & ((i % 2 == 1) ? (~gate_reg[tpw_pkg::TPW_GATE_HI_EN] | chop_reg)
                          : (~gate_reg[tpw_pkg::TPW_GATE_LO_EN] | chop_reg));
      end
    end
  end

  // final gating is unclocked so a trip acts at once
  assign phase_a_high_out_o = out_reg[5] & ~shut_any;
  assign phase_a_low_out_o = out_reg[4] & ~shut_any;
  assign phase_b_high_out_o = out_reg[3] & ~shut_any;
  assign phase_b_low_out_o = out_reg[2] & ~shut_any;
  assign phase_c_high_out_o = out_reg[1] & ~shut_any;
  assign phase_c_low_out_o = out_reg[0] & ~shut_any;

endmodule

// ==== sim/tpw_fault_model.sv ====
// far-side model: trip source and current-sense comparators
`timescale 1ns/1ps
module tpw_fault_model (
  input wire logic trip_req_i,
  input wire logic [8:0] sense_req_i,
  output logic trip_pin_n_o,
  output tpw_pkg::tpw_sense_s sense_o
);
  // trip source pulls the active-low pin down while asked to
  assign trip_pin_n_o = !trip_req_i;
  // over, under and open-channel comparators, three bits each, one per channel
  assign sense_o = tpw_pkg::tpw_sense_s'(sense_req_i);
endmodule

// ==== sim/tpw_pwm_ctrl_monitor.sv ====
// port-level assertion checker for the three-phase pwm controller
`timescale 1ns/1ps
module tpw_pwm_ctrl_monitor (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pslverr_o,
  input wire logic trip_pin_n_i,
  input wire tpw_pkg::tpw_sense_s current_sense_input_i,
  input wire logic phase_a_high_out_o,
  input wire logic phase_a_low_out_o,
  input wire logic phase_b_high_out_o,
  input wire logic phase_b_low_out_o,
  input wire logic phase_c_high_out_o,
  input wire logic phase_c_low_out_o,
  input wire logic period_sync_pulse_o,
  input wire logic sync_irq_o,
  input wire logic shutdown_irq_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic [5:0] outs;
  logic [7:0] sw_sh;
  logic [7:0] sw_act;
  logic [8:0] hi_cnt;
  logic wr_acc;
  assign outs = {phase_a_high_out_o, phase_a_low_out_o, phase_b_high_out_o,
                 phase_b_low_out_o, phase_c_high_out_o, phase_c_low_out_o};
  assign wr_acc = psel_i && penable_i && pwrite_i && ce_i;
  // shadow sync width, made active as the pulse rises
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sw_sh <= 8'h27;
      sw_act <= 8'h27;
    end else begin
      if (wr_acc && paddr_i == tpw_pkg::TPW_OFS_SYNC_WIDTH) sw_sh <= pwdata_i[7:0];
      if (period_sync_pulse_o && hi_cnt == 9'h000) sw_act <= sw_sh;
    end
  end
  // cycles the sync pulse has been high
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !period_sync_pulse_o) hi_cnt <= 9'h000;
    else hi_cnt <= hi_cnt + 9'h001;
  end
  sequence trip_held;
    !trip_pin_n_i [*4];
  endsequence
  trip_off_a: assert property (!trip_pin_n_i |-> outs == 6'h00)
    else $error("gate output on while trip pin low");
  sense_off_a: assert property (|current_sense_input_i |-> outs == 6'h00)
    else $error("gate output on during sense fault");
  no_overlap_a: assert property (!(outs[5] && outs[4]) && !(outs[3] && outs[2])
    && !(outs[1] && outs[0]))
    else $error("both sides of a phase on");
  sync_irq_a: assert property (sync_irq_o == $rose(period_sync_pulse_o))
    else $error("sync interrupt not with sync rise");
  sync_width_a: assert property ($fell(period_sync_pulse_o) |->
    hi_cnt == {1'b0, sw_act} + 9'h001)
    else $error("sync pulse width wrong");
  unmapped_err_a: assert property (psel_i && penable_i |->
    pslverr_o == (paddr_i > tpw_pkg::TPW_OFS_STATUS))
    else $error("slave error flag wrong");
  shut_once_a: assert property (shutdown_irq_o |=> !shutdown_irq_o)
    else $error("shutdown interrupt longer than one cycle");
  trip_halt_a: assert property (trip_held |-> !sync_irq_o)
    else $error("sync while tripped");
  soft_off_a: assert property (wr_acc && paddr_i == tpw_pkg::TPW_OFS_SOFT_SHUT
    |-> ##2 outs == 6'h00)
    else $error("outputs on after soft shutdown");
endmodule

// ==== sim/tb_top.sv ====
// self-checking bench for the three-phase pwm controller
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic pready, pslverr, trip_req = 0, trip_n, sync, sirq, shirq, h;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [8:0] sense_req = 9'h000;
  wire [5:0] outs;
  tpw_pkg::tpw_sense_s sense;
  int fails = 0, num_checks = 0, shn = 0, per, cnt[6];
  logic [31:0] rst_v[12] = '{32'h0000_03E8, 32'h0, 32'h0, 32'h27, 32'h0, 32'h0,
                             32'h0, 32'h3F, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [31:0] wr_v[10] = '{32'h0001_0014, 32'hFFFF_FC02, 32'h0, 32'h0103, 32'hC,
                            32'h0, 32'h14, 32'h3F, 32'h0, 32'h0};
  logic [31:0] ex_v[10] = '{32'h14, 32'h2, 32'h0, 32'h3, 32'hC, 32'h0, 32'h14,
                            32'h3F, 32'h0, 32'h0};
  always #2.5 clk = ~clk;
  // running count of shutdown interrupt pulses
  always @(posedge clk) if (shirq === 1'b1) shn++;
  tpw_pwm_ctrl dut (.core_clk_i(clk), .rst_i(rst), .ce_i(ce), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .trip_pin_n_i(trip_n),
    .current_sense_input_i(sense), .phase_a_high_out_o(outs[5]),
    .phase_a_low_out_o(outs[4]), .phase_b_high_out_o(outs[3]), .phase_b_low_out_o(outs[2]),
    .phase_c_high_out_o(outs[1]), .phase_c_low_out_o(outs[0]),
    .period_sync_pulse_o(sync), .sync_irq_o(sirq), .shutdown_irq_o(shirq));
  tpw_fault_model fm (.trip_req_i(trip_req), .sense_req_i(sense_req),
    .trip_pin_n_o(trip_n), .sense_o(sense));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer, then one idle edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (pready !== 1'b1) begin
      fails++;
      finish_test();
    end
  endtask
  task automatic wait_sync();
    per = 0;
    do begin
      @(posedge clk);
      per++;
    end while (sirq !== 1'b1 && per < 5000);
    if (sirq !== 1'b1) begin
      fails++;
      finish_test();
    end
  endtask
  // high cycles of each output over one full period
  task automatic measure(input int e[6]);
    wait_sync();
    wait_sync();
    chk("period cycles", 40, per);
    cnt = '{default: 0};
    repeat (40) begin
      @(posedge clk);
      foreach (cnt[i]) if (outs[5-i] !== 1'b0) cnt[i]++;
    end
    foreach (cnt[i]) chk("output high cycles", e[i], cnt[i]);
    $display("waveform test done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      xfer(1'b0, (i == 11) ? 8'h30 : 8'(4 * i), 32'h0);
      chk("reset value", rst_v[i], rd);
    end
    for (int i = 0; i < 10; i++) xfer(1'b1, 8'(4 * i), wr_v[i]);
    for (int i = 0; i < 10; i++) begin
      xfer(1'b0, 8'(4 * i), 32'h0);
      chk("register readback", ex_v[i], rd);
    end
    $display("register test done");
    measure('{20, 12, 0, 36, 36, 0});
    xfer(1'b1, 8'h08, 32'h7);
    measure('{20, 0, 0, 36, 36, 0});
    xfer(1'b1, 8'h08, 32'h0);
    xfer(1'b1, 8'h1C, 32'h13B);
    measure('{12, 20, 0, 0, 36, 0});
    xfer(1'b1, 8'h1C, 32'h3F);
    xfer(1'b1, 8'h20, 32'h100);
    measure('{10, 12, 0, 36, 18, 0});
    xfer(1'b1, 8'h20, 32'h0);
    xfer(1'b1, 8'h24, 32'h40);
    wait_sync();
    wait_sync();
    chk("half period cycles", 20, per);
    xfer(1'b0, 8'h2C, 32'h0);
    h = rd[3];
    wait_sync();
    xfer(1'b0, 8'h2C, 32'h0);
    chk("half flag toggle", 32'h1, {31'h0, h ^ rd[3]});
    xfer(1'b1, 8'h24, 32'h0);
    $display("update mode test done");
    for (int s = 0; s < 11; s++) begin
      repeat (4) @(posedge clk);
      if (s == 0) trip_req <= 1'b1;
      else if (s < 10) sense_req <= 9'(1 << (s - 1));
      else xfer(1'b1, 8'h28, 32'h1);
      #1;
      chk("outputs in shutdown", 32'h0, {26'h0, outs});
      repeat (4) @(posedge clk);
      chk("shutdown irq count", s + 1, shn);
      xfer(1'b0, 8'h2C, 32'h0);
      chk("shutdown status", (s == 0) ? 32'h2 : 32'h3, rd & 32'h3);
      trip_req <= 1'b0;
      sense_req <= 9'h000;
      xfer(1'b1, 8'h2C, 32'h2);
      wait_sync();
    end
    $display("shutdown test done");
    finish_test();
  end
endmodule
bind tpw_pwm_ctrl tpw_pwm_ctrl_monitor mon (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pslverr_o(pslverr_o),
  .trip_pin_n_i(trip_pin_n_i), .current_sense_input_i(current_sense_input_i),
  .phase_a_high_out_o(phase_a_high_out_o), .phase_a_low_out_o(phase_a_low_out_o),
  .phase_b_high_out_o(phase_b_high_out_o), .phase_b_low_out_o(phase_b_low_out_o),
  .phase_c_high_out_o(phase_c_high_out_o), .phase_c_low_out_o(phase_c_low_out_o),
  .period_sync_pulse_o(period_sync_pulse_o), .sync_irq_o(sync_irq_o),
  .shutdown_irq_o(shutdown_irq_o));
